// ===== logic/btw_pkg.sv
// Package with register map, codes and carrier types of the bound table walker
package btw_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_BST_LO = 8'h08;
  localparam logic [7:0] REG_BST_HI = 8'h0c;
  localparam logic [7:0] REG_CFG_LO = 8'h10;
  localparam logic [7:0] REG_CFG_HI = 8'h14;
  localparam logic [7:0] REG_OPA_LO = 8'h18;
  localparam logic [7:0] REG_OPA_HI = 8'h1c;
  localparam logic [7:0] REG_OPB_LO = 8'h20;
  localparam logic [7:0] REG_OPB_HI = 8'h24;
  localparam logic [7:0] REG_LOW_LO = 8'h28;
  localparam logic [7:0] REG_LOW_HI = 8'h2c;
  localparam logic [7:0] REG_UPP_LO = 8'h30;
  localparam logic [7:0] REG_UPP_HI = 8'h34;
  localparam logic [7:0] REG_PTR_LO = 8'h38;
  localparam logic [7:0] REG_PTR_HI = 8'h3c;
  localparam logic [7:0] REG_IST = 8'h40;
  localparam logic [7:0] REG_IMSK = 8'h44;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_WIDE_BIT = 4;
  localparam int CMD_BUSY_BIT = 0;

  // Operation codes
  localparam logic [2:0] OP_MAKE = 3'h1;
  localparam logic [2:0] OP_CHK_LO = 3'h2;
  localparam logic [2:0] OP_CHK_UPC = 3'h3;
  localparam logic [2:0] OP_CHK_UPN = 3'h4;
  localparam logic [2:0] OP_TSTORE = 3'h5;
  localparam logic [2:0] OP_TLOAD = 3'h6;

  // Status error codes
  localparam logic [1:0] EC_NONE = 2'h0;
  localparam logic [1:0] EC_VIOL = 2'h1;
  localparam logic [1:0] EC_BADDIR = 2'h2;

  // Field positions
  localparam int CFG_BASE_LSB = 12;
  localparam int DIR_VALID_BIT = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;

  // Table entry field indices
  localparam logic [1:0] FLD_LOWER = 2'h0;
  localparam logic [1:0] FLD_UPPER = 2'h1;
  localparam logic [1:0] FLD_PTR = 2'h2;

  // Reset values
  localparam logic [63:0] RST_WORD = 64'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;

  typedef enum {ST_IDLE, ST_DIR, ST_TBL} btw_state_t;

  typedef struct packed {
    logic req;
    logic we;
    logic wide;
    logic [63:0] addr;
    logic [63:0] wdata;
  } btw_mem_req_t;

endpackage

// ===== logic/btw_bound_walk.sv
// Bounds make/check unit with two-level bound table walker and Wishbone registers
`timescale 1ns/1ps

module btw_bound_walk (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [7:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic O_WB_ACK,
  output logic [31:0] O_WB_DAT,
  output btw_pkg::btw_mem_req_t O_MEM,
  input wire logic I_MEM_ACK,
  input wire logic [63:0] I_MEM_RDATA,
  output logic O_BUSY,
  output logic O_RANGE_FAULT,
  output logic O_IRQ
);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Narrow operands keep only the low word in 32-bit mode
  function automatic logic [63:0] fit(input logic [63:0] v, input logic wide);
    return wide ? v : {32'h0, v[31:0]};
  endfunction

  btw_pkg::btw_state_t state_q, state_d;
  btw_pkg::btw_mem_req_t mem_q, mem_d;
  logic ack_q, ack_d;
  logic [31:0] rd_q, rd_d;
  logic [63:0] bst_q, bst_d;
  logic [63:0] cfg_q, cfg_d;
  logic [63:0] opa_q, opa_d;
  logic [63:0] opb_q, opb_d;
  logic [63:0] low_q, low_d;
  logic [63:0] upp_q, upp_d;
  logic [63:0] ptr_q, ptr_d;
  logic [1:0] ist_q, ist_d;
  logic [1:0] imsk_q, imsk_d;
  logic [2:0] op_q, op_d;
  logic wide_q, wide_d;
  logic [1:0] idx_q, idx_d;
  logic [63:0] tbl_q, tbl_d;
  logic fault_q, fault_d;
  logic irq_q, irq_d;

  logic wb_req, wb_fire, cmd_go;
  logic [2:0] cmd_op;
  logic cmd_wide;
  logic [63:0] pointer_storage_linear_addr, dir_addr, tbl_addr, fld_addr;
  logic [63:0] chk_addr, chk_low, chk_upc, chk_upn;
  logic fail_lo, fail_upc, fail_upn;
  logic [1:0] set_ev, clr_ev;

  always_comb begin
    wb_req = I_WB_CYC & I_WB_STB;
    wb_fire = wb_req & ack_q;
    cmd_op = I_WB_DAT[btw_pkg::CMD_OP_LSB +: 3];
    cmd_wide = I_WB_DAT[btw_pkg::CMD_WIDE_BIT];
    cmd_go = wb_fire & I_WB_WE & (I_WB_ADR == btw_pkg::REG_CMD) & I_WB_SEL[0] & (state_q == btw_pkg::ST_IDLE);

    // Storage address of the pointer drives the whole walk
    pointer_storage_linear_addr = fit(opa_q, wide_q);
    if (wide_q) begin
      dir_addr = {cfg_q[63:btw_pkg::CFG_BASE_LSB], 12'h000} + {33'h0, pointer_storage_linear_addr[47:20], 3'h0};
    end else begin
      dir_addr = {32'h0, {cfg_q[31:btw_pkg::CFG_BASE_LSB], 12'h000} + {10'h0, pointer_storage_linear_addr[31:12], 2'h0}};
    end
    // Bits 2:1 of the entry are simply dropped by the shift in 64-bit mode, only bit 1 in 32-bit mode
    if (wide_q) begin
      tbl_addr = {I_MEM_RDATA[63:3], 3'h0} + {42'h0, pointer_storage_linear_addr[19:3], 5'h0};
    end else begin
      tbl_addr = {32'h0, {I_MEM_RDATA[31:2], 2'h0} + {18'h0, pointer_storage_linear_addr[11:2], 4'h0}};
    end
    fld_addr = tbl_q + (wide_q ? {59'h0, idx_q, 3'h0} : {60'h0, idx_q, 2'h0});

    chk_addr = fit(opa_q, cmd_wide);
    chk_low = fit(low_q, cmd_wide);
    chk_upc = fit(~upp_q, cmd_wide);
    chk_upn = fit(upp_q, cmd_wide);
    fail_lo = chk_addr < chk_low;
    fail_upc = chk_addr > chk_upc;
    fail_upn = chk_addr > chk_upn;
  end

  always_comb begin
    state_d = state_q;
    mem_d = mem_q;
    ack_d = wb_req & ~ack_q;
    rd_d = rd_q;
    bst_d = bst_q;
    cfg_d = cfg_q;
    opa_d = opa_q;
    opb_d = opb_q;
    low_d = low_q;
    upp_d = upp_q;
    ptr_d = ptr_q;
    imsk_d = imsk_q;
    op_d = op_q;
    wide_d = wide_q;
    idx_d = idx_q;
    tbl_d = tbl_q;
    fault_d = 1'b0;
    set_ev = 2'h0;
    clr_ev = 2'h0;

    // Read data is latched with the ack
    if (wb_req & ~ack_q & ~I_WB_WE) begin
      if (I_WB_ADR == btw_pkg::REG_CMD) begin
        rd_d = {27'h0, wide_q, 3'h0, state_q != btw_pkg::ST_IDLE};
      end else if (I_WB_ADR == btw_pkg::REG_BST_LO) begin
        rd_d = bst_q[31:0];
      end else if (I_WB_ADR == btw_pkg::REG_BST_HI) begin
        rd_d = bst_q[63:32];
      end else if (I_WB_ADR == btw_pkg::REG_CFG_LO) begin
        rd_d = cfg_q[31:0];
      end else if (I_WB_ADR == btw_pkg::REG_CFG_HI) begin
        rd_d = cfg_q[63:32];
      end else if (I_WB_ADR == btw_pkg::REG_OPA_LO) begin
        rd_d = opa_q[31:0];
      end else if (I_WB_ADR == btw_pkg::REG_OPA_HI) begin
        rd_d = opa_q[63:32];
      end else if (I_WB_ADR == btw_pkg::REG_OPB_LO) begin
        rd_d = opb_q[31:0];
      end else if (I_WB_ADR == btw_pkg::REG_OPB_HI) begin
        rd_d = opb_q[63:32];
      end else if (I_WB_ADR == btw_pkg::REG_LOW_LO) begin
        rd_d = low_q[31:0];
      end else if (I_WB_ADR == btw_pkg::REG_LOW_HI) begin
        rd_d = low_q[63:32];
      end else if (I_WB_ADR == btw_pkg::REG_UPP_LO) begin
        rd_d = upp_q[31:0];
      end else if (I_WB_ADR == btw_pkg::REG_UPP_HI) begin
        rd_d = upp_q[63:32];
      end else if (I_WB_ADR == btw_pkg::REG_PTR_LO) begin
        rd_d = ptr_q[31:0];
      end else if (I_WB_ADR == btw_pkg::REG_PTR_HI) begin
        rd_d = ptr_q[63:32];
      end else if (I_WB_ADR == btw_pkg::REG_IST) begin
        rd_d = {30'h0, ist_q};
      end else if (I_WB_ADR == btw_pkg::REG_IMSK) begin
        rd_d = {30'h0, imsk_q};
      end else begin
        rd_d = 32'h0;
      end
    end

    // Clear only what the read returned, so a later event survives
    if (wb_fire & ~I_WB_WE & (I_WB_ADR == btw_pkg::REG_IST)) begin
      clr_ev = rd_q[1:0];
    end

    // Operand and limit registers stay writable only while idle
    if (wb_fire & I_WB_WE & (state_q == btw_pkg::ST_IDLE)) begin
      if (I_WB_ADR == btw_pkg::REG_CFG_LO) begin
        cfg_d[31:0] = merge(cfg_q[31:0], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_CFG_HI) begin
        cfg_d[63:32] = merge(cfg_q[63:32], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_OPA_LO) begin
        opa_d[31:0] = merge(opa_q[31:0], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_OPA_HI) begin
        opa_d[63:32] = merge(opa_q[63:32], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_OPB_LO) begin
        opb_d[31:0] = merge(opb_q[31:0], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_OPB_HI) begin
        opb_d[63:32] = merge(opb_q[63:32], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_LOW_LO) begin
        low_d[31:0] = merge(low_q[31:0], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_LOW_HI) begin
        low_d[63:32] = merge(low_q[63:32], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_UPP_LO) begin
        upp_d[31:0] = merge(upp_q[31:0], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_UPP_HI) begin
        upp_d[63:32] = merge(upp_q[63:32], I_WB_DAT, I_WB_SEL);
      end else if (I_WB_ADR == btw_pkg::REG_IMSK) begin
        imsk_d = I_WB_SEL[0] ? I_WB_DAT[1:0] : imsk_q;
      end
    end

    case (state_q)
      btw_pkg::ST_IDLE: begin
        if (cmd_go) begin
          op_d = cmd_op;
          wide_d = cmd_wide;
          if (cmd_op == btw_pkg::OP_MAKE) begin
            low_d = fit(opb_q, cmd_wide);
            upp_d = fit(~opa_q, cmd_wide);
            set_ev[btw_pkg::IRQ_DONE_BIT] = 1'b1;
          end else if ((cmd_op == btw_pkg::OP_CHK_LO) | (cmd_op == btw_pkg::OP_CHK_UPC) |
                       (cmd_op == btw_pkg::OP_CHK_UPN)) begin
            if (((cmd_op == btw_pkg::OP_CHK_LO) & fail_lo) | ((cmd_op == btw_pkg::OP_CHK_UPC) & fail_upc) |
                ((cmd_op == btw_pkg::OP_CHK_UPN) & fail_upn)) begin
              fault_d = 1'b1;
              bst_d = {62'h0, btw_pkg::EC_VIOL};
              set_ev[btw_pkg::IRQ_FAULT_BIT] = 1'b1;
            end else begin
              set_ev[btw_pkg::IRQ_DONE_BIT] = 1'b1;
            end
          end else if ((cmd_op == btw_pkg::OP_TSTORE) | (cmd_op == btw_pkg::OP_TLOAD)) begin
            state_d = btw_pkg::ST_DIR;
          end
        end
      end
      btw_pkg::ST_DIR: begin
        if (~mem_q.req) begin
          mem_d.req = 1'b1;
          mem_d.we = 1'b0;
          mem_d.wide = wide_q;
          mem_d.addr = dir_addr;
          mem_d.wdata = 64'h0;
        end else if (I_MEM_ACK) begin
          if (I_MEM_RDATA[btw_pkg::DIR_VALID_BIT]) begin
            tbl_d = tbl_addr;
            idx_d = btw_pkg::FLD_LOWER;
            mem_d.req = 1'b0;
            state_d = btw_pkg::ST_TBL;
          end else begin
            fault_d = 1'b1;
            bst_d = {mem_q.addr[63:2], btw_pkg::EC_BADDIR};
            set_ev[btw_pkg::IRQ_FAULT_BIT] = 1'b1;
            mem_d.req = 1'b0;
            state_d = btw_pkg::ST_IDLE;
          end
        end
      end
      btw_pkg::ST_TBL: begin
        if (~mem_q.req) begin
          mem_d.req = 1'b1;
          mem_d.we = op_q == btw_pkg::OP_TSTORE;
          mem_d.addr = fld_addr;
          if (idx_q == btw_pkg::FLD_LOWER) begin
            mem_d.wdata = fit(low_q, wide_q);
          end else if (idx_q == btw_pkg::FLD_UPPER) begin
            mem_d.wdata = fit(upp_q, wide_q);
          end else begin
            mem_d.wdata = fit(opb_q, wide_q);
          end
        end else if (I_MEM_ACK) begin
          mem_d.req = 1'b0;
          if (~mem_q.we) begin
            if (idx_q == btw_pkg::FLD_LOWER) begin
              low_d = fit(I_MEM_RDATA, wide_q);
            end else if (idx_q == btw_pkg::FLD_UPPER) begin
              upp_d = fit(I_MEM_RDATA, wide_q);
            end else begin
              ptr_d = fit(I_MEM_RDATA, wide_q);
            end
          end
          // Reserved fourth field is never touched
          if (idx_q == btw_pkg::FLD_PTR) begin
            set_ev[btw_pkg::IRQ_DONE_BIT] = 1'b1;
            state_d = btw_pkg::ST_IDLE;
          end else begin
            idx_d = idx_q + 2'h1;
          end
        end
      end
      default: begin
        state_d = btw_pkg::ST_IDLE;
      end
    endcase

    // Hardware set wins over the read clear
    ist_d = (ist_q & ~clr_ev) | set_ev;
    irq_d = |(ist_d & imsk_d);
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RESETN) begin
      state_q <= btw_pkg::ST_IDLE;
      mem_q <= '0;
      ack_q <= 1'b0;
      rd_q <= 32'h0;
      bst_q <= btw_pkg::RST_WORD;
      cfg_q <= btw_pkg::RST_WORD;
      opa_q <= btw_pkg::RST_WORD;
      opb_q <= btw_pkg::RST_WORD;
      low_q <= btw_pkg::RST_WORD;
      upp_q <= btw_pkg::RST_WORD;
      ptr_q <= btw_pkg::RST_WORD;
      ist_q <= btw_pkg::RST_IRQ;
      imsk_q <= btw_pkg::RST_IRQ;
      op_q <= 3'h0;
      wide_q <= 1'b0;
      idx_q <= 2'h0;
      tbl_q <= btw_pkg::RST_WORD;
      fault_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mem_q <= mem_d;
      ack_q <= ack_d;
      rd_q <= rd_d;
      bst_q <= bst_d;
      cfg_q <= cfg_d;
      opa_q <= opa_d;
      opb_q <= opb_d;
      low_q <= low_d;
      upp_q <= upp_d;
      ptr_q <= ptr_d;
      ist_q <= ist_d;
      imsk_q <= imsk_d;
      op_q <= op_d;
      wide_q <= wide_d;
      idx_q <= idx_d;
      tbl_q <= tbl_d;
      fault_q <= fault_d;
      irq_q <= irq_d;
    end
  end

  assign O_WB_ACK = ack_q;
  assign O_WB_DAT = rd_q;
  assign O_MEM = mem_q;
  assign O_BUSY = state_q != btw_pkg::ST_IDLE;
  assign O_RANGE_FAULT = fault_q;
  assign O_IRQ = irq_q;

  a_wb_ack_single: assert property (@(posedge I_CLK) disable iff (!I_RESETN) ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

  a_make_limits: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    cmd_go && cmd_op == btw_pkg::OP_MAKE && cmd_wide |=> low_q == $past(opb_q) && upp_q == ~$past(opa_q))
    else $error("make did not load base and complemented address");

  a_check_lo_fault: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    cmd_go && cmd_op == btw_pkg::OP_CHK_LO && cmd_wide && opa_q < low_q |=> fault_q && bst_q[1:0] == btw_pkg::EC_VIOL)
    else $error("lower violation not faulted");

  a_check_pass_done: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    cmd_go && cmd_op == btw_pkg::OP_CHK_UPC && !fail_upc |=> !fault_q && ist_q[btw_pkg::IRQ_DONE_BIT])
    else $error("passing check did not complete");

  a_dir_index64: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_q == btw_pkg::ST_DIR && mem_q.req && wide_q |->
      mem_q.addr[2:0] == 3'h0 && mem_q.addr[30:3] == opa_q[47:20] + {cfg_q[30:12], 9'h0})
    else $error("directory entry address wrong");

  a_invalid_dir: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_q == btw_pkg::ST_DIR && mem_q.req && I_MEM_ACK && !I_MEM_RDATA[0] |=>
      fault_q && bst_q == {$past(mem_q.addr[63:2]), btw_pkg::EC_BADDIR} && state_q == btw_pkg::ST_IDLE)
    else $error("invalid directory entry not faulted");

  a_tbl_align64: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_q == btw_pkg::ST_TBL && mem_q.req && wide_q |-> mem_q.addr[2:0] == 3'h0 && idx_q <= btw_pkg::FLD_PTR)
    else $error("table access misaligned or reserved field touched");

  a_store_ptr_value: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    state_q == btw_pkg::ST_TBL && mem_q.req && mem_q.we && idx_q == btw_pkg::FLD_PTR |->
      mem_q.wdata == fit(opb_q, wide_q))
    else $error("stored pointer value differs from index operand");

  a_mem_hold: assert property (@(posedge I_CLK) disable iff (!I_RESETN)
    mem_q.req && !I_MEM_ACK |=> mem_q.req && $stable(mem_q.addr) && $stable(mem_q.we))
    else $error("memory request dropped before ack");

endmodule // btw_bound_walk

// ===== tb/btw_mem_model.sv
// Memory model holding the bound directory and tables seen by the walker
`timescale 1ns/1ps
module btw_mem_model (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire btw_pkg::btw_mem_req_t i_mem,
  input wire logic [7:0] i_lat,
  output logic o_ack,
  output logic [63:0] o_rdata
);
  logic [63:0] mem [logic [63:0]];
  logic [7:0] cnt;
  int accesses;
  initial begin
    o_ack = 1'h0;
    o_rdata = 64'h0;
    cnt = 8'h0;
    accesses = 0;
  end
  always @(posedge i_clk) begin
    o_ack <= 1'h0;
    // Stale read data toggles so it never passes for valid
    o_rdata <= ~o_rdata;
    if (!i_resetn) begin
      cnt <= 8'h0;
    end else if (i_mem.req && !o_ack) begin
      if (cnt >= i_lat) begin
        cnt <= 8'h0;
        o_ack <= 1'h1;
        accesses++;
        if (i_mem.we) begin
          mem[i_mem.addr] = i_mem.wdata;
        end else begin
          o_rdata <= mem.exists(i_mem.addr) ? mem[i_mem.addr] : 64'h0;
        end
      end else begin
        cnt <= cnt + 8'h1;
      end
    end
  end
endmodule // btw_mem_model

// ===== tb/tb_btw_bound_walk.sv
// Register-level testbench of the bound table walker
`timescale 1ns/1ps
module tb_btw_bound_walk;
  localparam logic [63:0] base_a = 64'h0000_0fed_0000_1000;
  localparam logic [63:0] eff_a = 64'h0000_0fed_0000_10ff;
  localparam logic [63:0] ptr_v = 64'h0123_4567_89ab_cdef;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h0;
  logic [7:0] lat = 8'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rd;
  logic [31:0] rdat;
  logic ack, mem_ack, busy, fault, irq;
  logic [63:0] mem_rdata, q, da, ta, pointer_storage_linear_addr;
  logic [63:0] cfg = 64'h0000_1234_5678_9abc;
  logic [63:0] ca [6] = '{base_a - 64'h1, base_a, eff_a, eff_a + 64'h1, ~eff_a, ~eff_a + 64'h1};
  logic [2:0] co [6] = '{3'h2, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4};
  logic [63:0] cf [6] = '{64'h1, 64'h0, 64'h0, 64'h1, 64'h0, 64'h1};
  btw_pkg::btw_mem_req_t mreq;
  int err_count = 0;
  int comparisons = 0;
  int faults = 0;
  int f, a0;

  btw_bound_walk i_btw_bound_walk (.I_CLK(clk), .I_RESETN(resetn), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(dat), .O_WB_ACK(ack), .O_WB_DAT(rdat),
    .O_MEM(mreq), .I_MEM_ACK(mem_ack), .I_MEM_RDATA(mem_rdata), .O_BUSY(busy),
    .O_RANGE_FAULT(fault), .O_IRQ(irq));
  btw_mem_model i_btw_mem_model (.i_clk(clk), .i_resetn(resetn), .i_mem(mreq), .i_lat(lat),
    .o_ack(mem_ack), .o_rdata(mem_rdata));

  always #10 clk = ~clk;
  // Fault is a one-cycle pulse; falling edge sampling avoids racing the checks
  always @(negedge clk) begin
    if (fault === 1'h1) faults++;
  end

  task end_of_test;
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 50);
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    if (n >= 50) begin
      err_count++;
      end_of_test;
    end
  endtask

  task w64(input logic [7:0] a, input logic [63:0] d);
    wb(1'h1, a, d[31:0]);
    wb(1'h1, a + 8'h4, d[63:32]);
  endtask

  task r64(input logic [7:0] a, output logic [63:0] v);
    wb(1'h0, a, 32'h0);
    v[31:0] = rd;
    wb(1'h0, a + 8'h4, 32'h0);
    v[63:32] = rd;
  endtask

  // Walks end when busy drops; make and check finish at once
  task op(input logic [2:0] c, input logic wide);
    int n;
    wb(1'h1, btw_pkg::REG_CMD, {27'h0, wide, 1'h0, c});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy !== 1'h0 && n < 500);
    if (n >= 500) begin
      err_count++;
      end_of_test;
    end
  endtask

  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'h1;
    r64(btw_pkg::REG_BST_LO, q);
    chk(q, 64'h0);
    wb(1'h0, 8'hfc, 32'h0);
    chk({32'h0, rd}, 64'h0);
    wb(1'h1, btw_pkg::REG_IMSK, 32'h1);
    w64(btw_pkg::REG_OPB_LO, base_a);
    w64(btw_pkg::REG_OPA_LO, eff_a);
    op(btw_pkg::OP_MAKE, 1'h1);
    r64(btw_pkg::REG_LOW_LO, q);
    chk(q, base_a);
    r64(btw_pkg::REG_UPP_LO, q);
    chk(q, ~eff_a);
    chk({63'h0, irq}, 64'h1);
    wb(1'h0, btw_pkg::REG_IST, 32'h0);
    chk({32'h0, rd}, 64'h1);
    repeat (2) @(posedge clk);
    chk({63'h0, irq}, 64'h0);
    wb(1'h1, btw_pkg::REG_IMSK, 32'h0);
    // Boundary addresses on each side of every limit
    for (int i = 0; i < 6; i++) begin
      f = faults;
      w64(btw_pkg::REG_OPA_LO, ca[i]);
      op(co[i], 1'h1);
      chk(64'(faults - f), cf[i]);
    end
    r64(btw_pkg::REG_BST_LO, q);
    chk(q, 64'h1);
    chk({63'h0, irq}, 64'h0);
    wb(1'h0, btw_pkg::REG_IST, 32'h0);
    chk({32'h0, rd}, 64'h3);
    pointer_storage_linear_addr = 64'h0000_7abc_def1_2348;
    da = {cfg[63:12], 12'h0} + {33'h0, pointer_storage_linear_addr[47:20], 3'h0};
    ta = 64'h4000_0000 + {42'h0, pointer_storage_linear_addr[19:3], 5'h0};
    i_btw_mem_model.mem[da] = 64'h0000_0000_4000_0007;
    w64(btw_pkg::REG_CFG_LO, cfg);
    w64(btw_pkg::REG_OPA_LO, pointer_storage_linear_addr);
    w64(btw_pkg::REG_OPB_LO, ptr_v);
    lat <= 8'h2;
    a0 = i_btw_mem_model.accesses;
    op(btw_pkg::OP_TSTORE, 1'h1);
    chk(i_btw_mem_model.mem[ta], base_a);
    chk(i_btw_mem_model.mem[ta + 64'h8], ~eff_a);
    chk(i_btw_mem_model.mem[ta + 64'h10], ptr_v);
    chk(64'(i_btw_mem_model.accesses - a0), 64'h4);
    i_btw_mem_model.mem[ta] = 64'h11;
    i_btw_mem_model.mem[ta + 64'h8] = 64'h22;
    i_btw_mem_model.mem[ta + 64'h10] = 64'h33;
    lat <= 8'h7;
    op(btw_pkg::OP_TLOAD, 1'h1);
    r64(btw_pkg::REG_LOW_LO, q);
    chk(q, 64'h11);
    r64(btw_pkg::REG_UPP_LO, q);
    chk(q, 64'h22);
    r64(btw_pkg::REG_PTR_LO, q);
    chk(q, 64'h33);
    wb(1'h0, btw_pkg::REG_CMD, 32'h0);
    chk({32'h0, rd}, 64'h10);
    // Next directory entry has valid clear but ignored bits set
    i_btw_mem_model.mem[da + 64'h8] = 64'h0000_0000_5000_0006;
    w64(btw_pkg::REG_OPA_LO, pointer_storage_linear_addr + 64'h10_0000);
    f = faults;
    op(btw_pkg::OP_TSTORE, 1'h1);
    chk(64'(faults - f), 64'h1);
    r64(btw_pkg::REG_BST_LO, q);
    chk(q, da + 64'ha);
    pointer_storage_linear_addr = 64'h0000_0000_89ab_c5f4;
    da = {32'h0, cfg[31:12], 12'h0} + {42'h0, pointer_storage_linear_addr[31:12], 2'h0};
    ta = 64'h2000_0100 + {50'h0, pointer_storage_linear_addr[11:2], 4'h0};
    i_btw_mem_model.mem[da] = 64'h0000_0000_2000_0103;
    w64(btw_pkg::REG_OPA_LO, pointer_storage_linear_addr);
    w64(btw_pkg::REG_LOW_LO, base_a);
    w64(btw_pkg::REG_UPP_LO, ~eff_a);
    lat <= 8'h0;
    op(btw_pkg::OP_TSTORE, 1'h0);
    chk(i_btw_mem_model.mem[ta], {32'h0, base_a[31:0]});
    chk(i_btw_mem_model.mem[ta + 64'h4], {32'h0, ~eff_a[31:0]});
    chk(i_btw_mem_model.mem[ta + 64'h8], {32'h0, ptr_v[31:0]});
    wb(1'h0, btw_pkg::REG_CMD, 32'h0);
    chk({32'h0, rd}, 64'h0);
    // Narrow make keeps only the low words, zero-extended
    op(btw_pkg::OP_MAKE, 1'h0);
    r64(btw_pkg::REG_LOW_LO, q);
    chk(q, {32'h0, ptr_v[31:0]});
    r64(btw_pkg::REG_UPP_LO, q);
    chk(q, {32'h0, ~pointer_storage_linear_addr[31:0]});
    // Low word of the address sits below the narrow lower limit
    f = faults;
    op(btw_pkg::OP_CHK_LO, 1'h0);
    chk(64'(faults - f), 64'h1);
    end_of_test;
  end
endmodule // tb_btw_bound_walk
